// >>> design/uart_status_flags.sv
// How it works
// R1: Status register is read-only; writes ignored.
// R2: Buffer empty set at reset and load.
// R3: Status read then data write clears empty.
// R4: Complete set when empty and shifter idle.
// R5: Complete cleared by write, enable rise, break.
// R6: Receive full set when character is stored.
// R7: Status read then data read clears full.
// R8: Idle after 10 or 11 high bit times.
// R9: Idle select chooses start or stop count.
// R10: Status read then data read clears idle.
// R11: Idle sets once, only after a new character.
// R12: Overrun when unread; new character is dropped.
// R13: Status read then data read clears overrun.
// R14: Seven start samples, three per bit; noise.
// R15: Noise cleared by any read pair.
// R16: Framing error when stop bit reads low.
// R17: Status read then data read clears framing.
// R18: Parity error flag on mismatch when enabled.
// R19: Parity flag cleared by any read pair.
// R20: Character MSB serves as the parity bit.
// R21: Parity type selects even or odd.
// R22: Only flags seen at status read clear, except noise and parity.
//
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module uart_status_flags (
    input  wire logic       CORE_CLK_I,
    input  wire logic       SYS_RST_I,
    input  wire logic [2:0] ADDR_I,
    input  wire logic [7:0] WDATA_I,
    input  wire logic       WR_I,
    input  wire logic       RD_I,
    output logic      [7:0] RDATA_O,
    input  wire logic       RX_PIN_I,
    input  wire logic       RX_BIT_TICK_I,
    input  wire logic       RX_BIT_STROBE_I,
    input  wire logic       RX_START_I,
    input  wire logic [6:0] RX_SAMPLES_I,
    input  wire logic       TX_TAKE_I,
    input  wire logic       TX_BUSY_I,
    output logic            TX_VALID_O,
    output logic      [8:0] TX_DATA_O,
    output logic            TX_ON_O,
    output logic            TX_BREAK_O,
    output logic            TX_PREAMBLE_O,
    output logic            NINE_BIT_O
);

    typedef struct packed {
        logic [7:0]                flags;
        logic [7:0]                armed;
        logic [7:0]                rd_data;
        logic [8:0]                rx_buf;
        logic [8:0]                rx_acc;
        logic [3:0]                bit_cnt;
        logic                      noise_acc;
        uart_flags_pkg::rx_state_t rx_state;
        logic [8:0]                tx_buf;
        logic                      tx9;
        logic [7:0]                ctrl;
        logic                      done_wait;
        logic                      preamble;
        logic [2:0]                sync;
        logic                      line;
        logic [3:0]                idle_cnt;
        logic                      idle_armed;
    } state_t;

    state_t     st_reg;
    state_t     st_next;

    logic       start_level;
    logic       start_noise;
    logic       bit_level;
    logic       bit_noise;
    logic [7:0] clr;
    logic [8:0] rx_char;
    logic [3:0] data_bits;
    logic [3:0] idle_bits;
    logic       rx_parity;
    logic       tx_parity;
    logic [8:0] tx_word;
    logic       new_char;
    logic       char_noise;
    logic       char_frame;
    logic       char_parity;

    // Start bit votes over seven samples, every other bit over three.
    sample_vote #(
        .N          (uart_flags_pkg::SAMPLES_START)
    ) u_vote_start (
        .samples_i  (RX_SAMPLES_I),
        .level_o    (start_level),
        .disagree_o (start_noise)
    );

    sample_vote #(
        .N          (uart_flags_pkg::SAMPLES_BIT)
    ) u_vote_bit (
        .samples_i  (RX_SAMPLES_I[2:0]),
        .level_o    (bit_level),
        .disagree_o (bit_noise)
    );

    always_comb begin
        st_next     = st_reg;
        clr         = 8'h00;
        new_char    = 1'b0;
        char_noise  = 1'b0;
        char_frame  = 1'b0;
        char_parity = 1'b0;
        rx_char     = 9'h000;
        rx_parity   = 1'b0;
        tx_parity   = 1'b0;
        tx_word     = 9'h000;

        data_bits = st_reg.ctrl[uart_flags_pkg::CTRL_NINE]
                    ? uart_flags_pkg::DATA_BITS_9
                    : uart_flags_pkg::DATA_BITS_8;
        idle_bits = st_reg.ctrl[uart_flags_pkg::CTRL_NINE]
                    ? uart_flags_pkg::IDLE_BITS_9
                    : uart_flags_pkg::IDLE_BITS_8;

        // Read data stand only in the cycle after the read strobe.
        st_next.rd_data  = 8'h00;
        st_next.preamble = 1'b0;

        // Three-stage synchroniser; a change counts once stages agree.
        st_next.sync = {st_reg.sync[1:0], RX_PIN_I};
        if (st_reg.sync[1] == st_reg.sync[2]) begin
            st_next.line = st_reg.sync[2];
        end

        // Register reads.
        if (RD_I) begin
            unique case (ADDR_I)
                uart_flags_pkg::ADDR_STAT: begin
                    st_next.rd_data = st_reg.flags;
                    // Remember which flags were seen at this read.
                    st_next.armed = st_reg.flags
                                  | uart_flags_pkg::ALWAYS_ARMED; // R22 R15 R19
                end
                uart_flags_pkg::ADDR_DATA: begin
                    st_next.rd_data = st_reg.rx_buf[7:0];
                    clr = st_reg.armed & uart_flags_pkg::RX_CLR_MASK; // R7 R10 R13 R15 R17 R19 R22
                end
                uart_flags_pkg::ADDR_CTRL: begin
                    st_next.rd_data = st_reg.ctrl;
                end
                uart_flags_pkg::ADDR_NINTH: begin
                    st_next.rd_data[uart_flags_pkg::NINTH_RX] =
                        st_reg.rx_buf[8];
                    st_next.rd_data[uart_flags_pkg::NINTH_TX] =
                        st_reg.tx9;
                end
                default: begin
                    st_next.rd_data = 8'h00;
                end
            endcase
        end

        // Register writes; the status address takes no write.
        if (WR_I) begin
            unique case (ADDR_I)
                uart_flags_pkg::ADDR_STAT: begin
                    st_next.flags = st_reg.flags; // R1
                end
                uart_flags_pkg::ADDR_DATA: begin
                    // The character MSB carries the parity when enabled.
                    tx_word = {st_reg.tx9, WDATA_I};
                    if (st_reg.ctrl[uart_flags_pkg::CTRL_PAR_EN]) begin
                        if (st_reg.ctrl[uart_flags_pkg::CTRL_NINE]) begin
                            tx_parity = (^WDATA_I)
                                ^ st_reg.ctrl[uart_flags_pkg::CTRL_PAR_ODD]; // R21
                            tx_word[8] = tx_parity; // R20
                        end else begin
                            tx_parity = (^WDATA_I[6:0])
                                ^ st_reg.ctrl[uart_flags_pkg::CTRL_PAR_ODD]; // R21
                            tx_word[7] = tx_parity; // R20
                        end
                    end
                    st_next.tx_buf = tx_word;
                    clr = st_reg.armed & uart_flags_pkg::TX_CLR_MASK; // R3 R5 R22
                end
                uart_flags_pkg::ADDR_CTRL: begin
                    st_next.ctrl = WDATA_I;
                    if (WDATA_I[uart_flags_pkg::CTRL_TX_ON]
                        && !st_reg.ctrl[uart_flags_pkg::CTRL_TX_ON]) begin
                        st_next.preamble = 1'b1;
                    end
                    if ((WDATA_I[uart_flags_pkg::CTRL_TX_ON]
                         && !st_reg.ctrl[uart_flags_pkg::CTRL_TX_ON])
                        || WDATA_I[uart_flags_pkg::CTRL_BREAK]) begin
                        clr[uart_flags_pkg::BIT_DONE] =
                            st_reg.armed[uart_flags_pkg::BIT_DONE]; // R5 R22
                    end
                end
                uart_flags_pkg::ADDR_NINTH: begin
                    st_next.tx9 = WDATA_I[uart_flags_pkg::NINTH_TX];
                end
                default: begin
                    st_next.tx9 = st_reg.tx9;
                end
            endcase
        end

        // A completed access sequence consumes its arming.
        st_next.flags = st_next.flags & ~clr;
        st_next.armed = st_next.armed & ~clr;

        // Keep the complete flag down until queued work reaches the shifter.
        if (clr[uart_flags_pkg::BIT_DONE]) begin
            st_next.done_wait = 1'b1;
        end
        if (TX_BUSY_I) begin
            st_next.done_wait = 1'b0;
        end

        // Transmit events; the empty set follows the clears so it wins, but a done clear blocks the done set.
        if (TX_TAKE_I) begin
            st_next.flags[uart_flags_pkg::BIT_EMPTY] = 1'b1; // R2
        end
        if (st_next.flags[uart_flags_pkg::BIT_EMPTY] && !TX_BUSY_I
            && !st_next.done_wait && !clr[uart_flags_pkg::BIT_DONE]) begin
            st_next.flags[uart_flags_pkg::BIT_DONE] = 1'b1; // R4
        end

        // Character assembly from voted bit levels.
        if (RX_BIT_STROBE_I) begin
            unique case (st_reg.rx_state)
                uart_flags_pkg::RX_WAIT: begin
                    if (RX_START_I && !start_level) begin
                        st_next.rx_state  = uart_flags_pkg::RX_BITS;
                        st_next.bit_cnt   = 4'h0;
                        st_next.rx_acc    = 9'h000;
                        st_next.noise_acc = start_noise; // R14
                    end
                end
                uart_flags_pkg::RX_BITS: begin
                    st_next.noise_acc = st_reg.noise_acc | bit_noise; // R14
                    if (st_reg.bit_cnt < data_bits) begin
                        st_next.rx_acc  = {bit_level, st_reg.rx_acc[8:1]};
                        st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
                    end else begin
                        st_next.rx_state = uart_flags_pkg::RX_WAIT;
                        new_char   = 1'b1;
                        char_noise = st_reg.noise_acc | bit_noise; // R14
                        char_frame = !bit_level; // R16
                    end
                end
            endcase
        end

        if (new_char) begin
            rx_char = st_reg.ctrl[uart_flags_pkg::CTRL_NINE]
                      ? st_reg.rx_acc
                      : {1'b0, st_reg.rx_acc[8:1]};
            rx_parity = ^rx_char;
            // Parity bit is inside the character, so the whole count is checked.
            char_parity = st_reg.ctrl[uart_flags_pkg::CTRL_PAR_EN]
                && (rx_parity != st_reg.ctrl[uart_flags_pkg::CTRL_PAR_ODD]); // R18 R20 R21
            if (st_next.flags[uart_flags_pkg::BIT_FULL]) begin
                // Unread data stay; the new character and its errors are lost.
                st_next.flags[uart_flags_pkg::BIT_OR] = 1'b1; // R12
            end else begin
                st_next.rx_buf = rx_char;
                st_next.flags[uart_flags_pkg::BIT_FULL]   = 1'b1; // R6
                st_next.flags[uart_flags_pkg::BIT_NOISE]  = char_noise; // R14
                st_next.flags[uart_flags_pkg::BIT_FRAME]  = char_frame; // R16
                st_next.flags[uart_flags_pkg::BIT_PARITY] = char_parity; // R18
                st_next.idle_armed = 1'b1; // R11
            end
        end

        // Idle line: count high bit times at each bit tick.
        if (RX_BIT_TICK_I) begin
            if (!st_reg.line) begin
                st_next.idle_cnt = 4'h0; // R8
            end else if (st_reg.ctrl[uart_flags_pkg::CTRL_IDLE_SEL]
                         && (st_reg.rx_state == uart_flags_pkg::RX_BITS)) begin
                st_next.idle_cnt = 4'h0; // R9
            end else if (st_reg.idle_cnt < idle_bits) begin
                st_next.idle_cnt = st_reg.idle_cnt + 4'h1; // R8 R9
            end
        end
        if (st_next.idle_cnt >= idle_bits && st_next.idle_armed
            && !new_char) begin
            st_next.flags[uart_flags_pkg::BIT_IDLE] = 1'b1; // R8
            st_next.idle_armed = 1'b0; // R11
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            st_reg.flags      <= uart_flags_pkg::STAT_RST; // R2 R4
            st_reg.armed      <= 8'h00;
            st_reg.rd_data    <= 8'h00;
            st_reg.rx_buf     <= 9'h000;
            st_reg.rx_acc     <= 9'h000;
            st_reg.bit_cnt    <= 4'h0;
            st_reg.noise_acc  <= 1'b0;
            st_reg.rx_state   <= uart_flags_pkg::RX_WAIT;
            st_reg.tx_buf     <= 9'h000;
            st_reg.tx9        <= 1'b0;
            st_reg.ctrl       <= uart_flags_pkg::CTRL_RST;
            st_reg.done_wait  <= 1'b0;
            st_reg.preamble   <= 1'b0;
            st_reg.sync       <= uart_flags_pkg::SYNC_RST;
            st_reg.line       <= 1'b1;
            st_reg.idle_cnt   <= 4'h0;
            st_reg.idle_armed <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign RDATA_O       = st_reg.rd_data;
    assign TX_VALID_O    = !st_reg.flags[uart_flags_pkg::BIT_EMPTY];
    assign TX_DATA_O     = st_reg.tx_buf;
    assign TX_ON_O       = st_reg.ctrl[uart_flags_pkg::CTRL_TX_ON];
    assign TX_BREAK_O    = st_reg.ctrl[uart_flags_pkg::CTRL_BREAK];
    assign TX_PREAMBLE_O = st_reg.preamble;
    assign NINE_BIT_O    = st_reg.ctrl[uart_flags_pkg::CTRL_NINE];

endmodule // uart_status_flags

`default_nettype wire

// >>> design/uart_flags_pkg.sv
package uart_flags_pkg;

    // Register map, one byte per address.
    localparam int          ADDR_W     = 3;
    localparam logic [2:0]  ADDR_STAT  = 3'h0;
    localparam logic [2:0]  ADDR_DATA  = 3'h1;
    localparam logic [2:0]  ADDR_CTRL  = 3'h2;
    localparam logic [2:0]  ADDR_NINTH = 3'h3;

    // Flag positions in serial_status_one.
    localparam int BIT_EMPTY  = 7;
    localparam int BIT_DONE   = 6;
    localparam int BIT_FULL   = 5;
    localparam int BIT_IDLE   = 4;
    localparam int BIT_OR     = 3;
    localparam int BIT_NOISE  = 2;
    localparam int BIT_FRAME  = 1;
    localparam int BIT_PARITY = 0;

    // Control register fields.
    localparam int CTRL_NINE     = 5;
    localparam int CTRL_IDLE_SEL = 4;
    localparam int CTRL_TX_ON    = 3;
    localparam int CTRL_PAR_EN   = 2;
    localparam int CTRL_PAR_ODD  = 1;
    localparam int CTRL_BREAK    = 0;

    // Ninth bit register fields.
    localparam int NINTH_RX = 7;
    localparam int NINTH_TX = 6;

    // Values after reset.
    localparam logic [7:0] STAT_RST  = 8'hC0;
    localparam logic [7:0] CTRL_RST  = 8'h00;
    localparam logic [2:0] SYNC_RST  = 3'h7;

    // Flags cleared by a data read, those cleared by a data write, and those any status read arms.
    localparam logic [7:0] RX_CLR_MASK  = 8'h3F;
    localparam logic [7:0] TX_CLR_MASK  = 8'hC0;
    localparam logic [7:0] ALWAYS_ARMED = 8'h05;

    // Bit times of high level that make an idle line.
    localparam logic [3:0] IDLE_BITS_8 = 4'hA;
    localparam logic [3:0] IDLE_BITS_9 = 4'hB;

    // Data bits per character.
    localparam logic [3:0] DATA_BITS_8 = 4'h8;
    localparam logic [3:0] DATA_BITS_9 = 4'h9;

    // Samples taken in the start bit and in every other bit.
    localparam int SAMPLES_START = 7;
    localparam int SAMPLES_BIT   = 3;

    typedef enum logic [1:0] {
        RX_WAIT = 2'b01,
        RX_BITS = 2'b10
    } rx_state_t;

endpackage

// >>> design/sample_vote.sv
`timescale 1ns/1ps
`default_nettype none

// Majority level of a group of samples and whether any sample dissents.
module sample_vote #(
    parameter int N = 3
) (
    input  wire logic [N-1:0] samples_i,
    output logic              level_o,
    output logic              disagree_o
);

    logic [7:0] ones;

    always_comb begin
        ones = 8'h00;
        for (int i = 0; i < N; i++) begin
            ones = ones + {7'h00, samples_i[i]};
        end
        level_o    = (ones > 8'(N / 2));
        disagree_o = (ones != 8'h00) && (ones != 8'(N));
    end

endmodule // sample_vote

`default_nettype wire

// >>> verification/uart_flags_props.sv
`timescale 1ns/1ps
`default_nettype none
module uart_flags_props (
    input wire logic       CORE_CLK_I,
    input wire logic       SYS_RST_I,
    input wire logic [2:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic       WR_I,
    input wire logic       RD_I,
    input wire logic [7:0] RDATA_O,
    input wire logic       TX_TAKE_I,
    input wire logic       TX_VALID_O,
    input wire logic [8:0] TX_DATA_O,
    input wire logic       TX_ON_O,
    input wire logic       TX_BREAK_O,
    input wire logic       TX_PREAMBLE_O,
    input wire logic       NINE_BIT_O
);
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (SYS_RST_I);
    logic cw;
    logic dw;
    assign cw = WR_I && ADDR_I == uart_flags_pkg::ADDR_CTRL;
    assign dw = WR_I && ADDR_I == uart_flags_pkg::ADDR_DATA;
    a_rdata_idle: assert property (!$past(RD_I) |-> RDATA_O == 8'h00)
        else $error("read data not zero outside answer cycle");
    a_stat_write: assert property (WR_I && ADDR_I == 3'h0 && !TX_TAKE_I
        |=> $stable({TX_VALID_O, TX_DATA_O, TX_ON_O, TX_BREAK_O}))
        else $error("status write changed outputs");
    a_take_empties: assert property (TX_TAKE_I && !dw |=> !TX_VALID_O)
        else $error("buffer not empty after take");
    a_valid_holds: assert property (TX_VALID_O && !TX_TAKE_I
        |=> TX_VALID_O) else $error("buffer emptied without take");
    a_data_loads: assert property (dw
        |=> TX_DATA_O[6:0] == $past(WDATA_I[6:0]))
        else $error("transmit word not loaded");
    a_ctrl_mirror: assert property (cw |=> {TX_ON_O, TX_BREAK_O,
        NINE_BIT_O} == {$past(WDATA_I[3]), $past(WDATA_I[0]),
        $past(WDATA_I[5])}) else $error("control bits wrong");
    a_ctrl_holds: assert property (!cw && !$past(SYS_RST_I)
        |=> $stable({TX_ON_O, TX_BREAK_O, NINE_BIT_O}))
        else $error("control bits moved");
    a_preamble_cause: assert property (TX_PREAMBLE_O
        |-> $rose(TX_ON_O) && $past(cw)) else $error("stray preamble");
    a_preamble_pulse: assert property (TX_PREAMBLE_O |=> !TX_PREAMBLE_O)
        else $error("preamble longer than one cycle");
    c_take: cover property (TX_TAKE_I);
    c_preamble: cover property (TX_PREAMBLE_O);
    c_data_read: cover property (RD_I && ADDR_I == 3'h1 ##1 RDATA_O != 0);
endmodule // uart_flags_props
bind uart_status_flags uart_flags_props u_props (
    .CORE_CLK_I(CORE_CLK_I), .SYS_RST_I(SYS_RST_I), .ADDR_I(ADDR_I),
    .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
    .TX_TAKE_I(TX_TAKE_I), .TX_VALID_O(TX_VALID_O),
    .TX_DATA_O(TX_DATA_O), .TX_ON_O(TX_ON_O), .TX_BREAK_O(TX_BREAK_O),
    .TX_PREAMBLE_O(TX_PREAMBLE_O), .NINE_BIT_O(NINE_BIT_O));
`default_nettype wire

// >>> verification/serial_node.sv
`timescale 1ns/1ps
`default_nettype none
module serial_node (
    input  wire logic       clk_i,
    input  wire logic       tx_valid_i,
    input  wire logic       tx_preamble_i,
    output logic            pin_o,
    output logic            tick_o,
    output logic            strobe_o,
    output logic            start_o,
    output logic      [6:0] samples_o,
    output logic            take_o,
    output logic            busy_o
);
    logic [2:0] ph = 3'h0;
    always @(posedge clk_i) ph <= ph + 3'h1;
    assign tick_o = ph == 3'h7;
    initial begin
        pin_o = 1'b1;
        strobe_o = 1'b0;
        start_o = 1'b0;
        samples_o = 7'h00;
    end
    // One bit time is eight cycles; nz makes one sample dissent.
    task automatic bit_out(input logic l, input logic st, input logic nz);
        @(posedge clk_i);
        while (ph != 3'h0) @(posedge clk_i);
        pin_o <= l;
        repeat (4) @(posedge clk_i);
        strobe_o <= 1'b1;
        start_o <= st;
        samples_o <= {7{l}} ^ {6'h00, nz};
        @(posedge clk_i);
        strobe_o <= 1'b0;
        start_o <= 1'b0;
        samples_o <= ~samples_o;
    endtask
    task automatic send(input logic [7:0] d, input logic nz, input logic sb);
        bit_out(1'b0, 1'b1, 1'b0);
        for (int i = 0; i < 8; i++) bit_out(d[i], 1'b0, nz && i == 0);
        bit_out(sb, 1'b0, 1'b0);
        repeat (3) @(posedge clk_i);
        pin_o <= 1'b1;
    endtask
    // Shifter side: takes a loaded word, or sends a preamble, then busy.
    initial begin
        take_o = 1'b0;
        busy_o = 1'b0;
        forever begin
            @(posedge clk_i);
            if (tx_valid_i || tx_preamble_i) begin
                repeat (8) @(posedge clk_i);
                take_o <= tx_valid_i;
                busy_o <= 1'b1;
                @(posedge clk_i);
                take_o <= 1'b0;
                repeat (10) @(posedge clk_i);
                busy_o <= 1'b0;
            end
        end
    end
endmodule // serial_node
`default_nettype wire

// >>> verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic [6:0] samples;
    logic [8:0] txd;
    logic       pin, tick, strobe, start, take, busy;
    logic       valid, ton, brk, pre, nine;
    int         error_cnt = 0;
    int         comparisons = 0;
    always #12.5 clk = ~clk;
    uart_status_flags dut (
        .CORE_CLK_I(clk), .SYS_RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .RX_PIN_I(pin),
        .RX_BIT_TICK_I(tick), .RX_BIT_STROBE_I(strobe), .RX_START_I(start),
        .RX_SAMPLES_I(samples), .TX_TAKE_I(take), .TX_BUSY_I(busy),
        .TX_VALID_O(valid), .TX_DATA_O(txd), .TX_ON_O(ton),
        .TX_BREAK_O(brk), .TX_PREAMBLE_O(pre), .NINE_BIT_O(nine));
    serial_node node (
        .clk_i(clk), .tx_valid_i(valid), .tx_preamble_i(pre), .pin_o(pin),
        .tick_o(tick), .strobe_o(strobe), .start_o(start),
        .samples_o(samples), .take_o(take), .busy_o(busy));
    task automatic summarize();
        if (error_cnt == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [8:0] s, logic [8:0] e);
        comparisons++;
        if (s !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic expect_reg(input logic [2:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk($sformatf("reg %0h", a), {1'b0, rdata}, {1'b0, e});
    endtask
    task automatic rx_case(input logic [7:0] c, d, input logic nz, sb,
                           input logic [7:0] e);
        wr_reg(3'h2, c);
        node.send(d, nz, sb);
        expect_reg(3'h0, e);
        expect_reg(3'h1, d);
        expect_reg(3'h0, 8'hC0);
    endtask
    initial begin
        #500000;
        error_cnt++;
        summarize();
    end
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        expect_reg(3'h0, 8'hC0);
        wr_reg(3'h0, 8'h00);
        expect_reg(3'h0, 8'hC0);
        expect_reg(3'h5, 8'h00);
        wr_reg(3'h2, 8'h08);
        #1;
        chk("preamble", {8'h00, pre}, 9'h001);
        chk("tx_on", {8'h00, ton}, 9'h001);
        expect_reg(3'h0, 8'h80);
        repeat (30) @(posedge clk);
        for (int k = 0; k < 2; k++) begin
            wr_reg(3'h2, k ? 8'h0E : 8'h0C);
            expect_reg(3'h0, 8'hC0);
            wr_reg(3'h1, 8'h01);
            expect_reg(3'h0, 8'h00);
            chk("valid", {8'h00, valid}, 9'h001);
            chk("txword", txd, {1'b0, k == 0, 7'h01});
            repeat (40) @(posedge clk);
        end
        rx_case(8'h08, 8'hA5, 1'b0, 1'b1, 8'hE0);
        rx_case(8'h08, 8'h3C, 1'b1, 1'b1, 8'hE4);
        rx_case(8'h08, 8'h3C, 1'b0, 1'b0, 8'hE2);
        rx_case(8'h0C, 8'h01, 1'b0, 1'b1, 8'hE1);
        rx_case(8'h0E, 8'h01, 1'b0, 1'b1, 8'hE0);
        rx_case(8'h0E, 8'h03, 1'b0, 1'b1, 8'hE1);
        wr_reg(3'h2, 8'h08);
        node.send(8'h11, 1'b0, 1'b1);
        node.send(8'h22, 1'b0, 1'b1);
        expect_reg(3'h0, 8'hE8);
        expect_reg(3'h1, 8'h11);
        expect_reg(3'h0, 8'hC0);
        for (int k = 0; k < 2; k++) begin
            wr_reg(3'h2, k ? 8'h18 : 8'h08);
            node.send(8'hFF, 1'b0, 1'b1);
            repeat (24) @(posedge clk);
            expect_reg(3'h0, k ? 8'hE0 : 8'hF0);
            repeat (80) @(posedge clk);
            expect_reg(3'h0, 8'hF0);
            expect_reg(3'h1, 8'hFF);
            expect_reg(3'h0, 8'hC0);
            repeat (120) @(posedge clk);
            expect_reg(3'h0, 8'hC0);
        end
        wr_reg(3'h3, 8'h40);
        wr_reg(3'h2, 8'h28);
        wr_reg(3'h1, 8'h55);
        #1;
        chk("txword9", txd, 9'h155);
        chk("nine", {8'h00, nine}, 9'h001);
        expect_reg(3'h3, 8'h40);
        repeat (40) @(posedge clk);
        expect_reg(3'h0, 8'hC0);
        wr_reg(3'h2, 8'h09);
        expect_reg(3'h0, 8'h80);
        chk("break", {8'h00, brk}, 9'h001);
        summarize();
    end
endmodule // tb
`default_nettype wire
